// *** cpu_ctrl_addr_gen.sv ***
// Control, start-up, interrupt entry, address generation and on-chip port.
// Operation
// (RL1) Six init cycles after cold start release, set mask, load PC from FFFC/FFFD.
// (RL2) System holds cold start low at least two clocks at power-up.
// (RL3) Direction line is valid (high) while cold start is held low.
// (RL4) Interrupt is recognised only at an instruction boundary.
// (RL5) Interrupt sequence starts only when the mask flag is clear.
// (RL6) Interrupt sequence pushes program counter and status onto the stack.
// (RL7) After stacking, the mask flag is set.
// (RL8) Interrupt sequence loads PC low from FFFE and high from FFFF.
// (RL9) Bus enable high drives address, direction, data; low floats all three.
// (RL10) Port output register at 0001, port direction register at 0000.
// (RL11) Direction line is high except in cycles writing memory or peripherals.
// (RL12) Accumulator mode uses no operand; immediate takes the second byte.
// (RL13) Absolute address is second byte low, third byte high.
// (RL14) Zero page address is second byte with high byte zero.
// (RL15) Zero page indexed adds X or Y and drops the carry.
// (RL16) Absolute indexed adds X or Y to the full 16-bit base.
// (RL17) Relative adds the signed second byte to the next-instruction PC.
// (RL18) Indexed indirect reads the pointer at byte2+X and the next page-zero byte.
// (RL19) Indirect indexed adds Y to the page-zero pointer with carry into high.
// (RL20) Absolute indirect reads two bytes at the 16-bit location into the PC.
// (RL21) Reading 0001 returns pin levels on bits set as inputs.
// (RL22) No write transfers while cold start is held low.
// (RL23) Reset sequence begins immediately on the cold start rising edge.
// (RL24) Direction bit one drives the pin from the output bit; zero is input.
// (RL25) Port accesses are internal and never appear on the data lines.
`timescale 1ns/1ps
`default_nettype none
module cpu_ctrl_addr_gen (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control inputs from the system.
    input wire logic cold_start_input_n,
    input wire logic irq_n,
    input wire logic bus_output_enable,
    // Instruction core side.
    input wire logic instr_boundary,
    input wire logic mask_set,
    input wire logic mask_clr,
    input wire logic [7:0] stack_ptr_in,
    input wire logic [7:0] status_in,
    input wire logic [15:0] pc_in,
    input wire logic cmd_valid,
    input wire cpu_ctrl_pkg::cmd_t cmd,
    output logic cmd_ready_q,
    output logic done_q,
    output logic [15:0] ea_q,
    output logic [7:0] rdata_q,
    output logic pc_load_q,
    output logic [15:0] pc_q,
    output logic [7:0] stack_ptr_q,
    output logic irq_mask_q,
    // External bus.
    output logic [15:0] address_lines_o,
    output logic address_lines_oe,
    output logic xfer_dir_o,
    output logic xfer_dir_oe,
    input wire logic [7:0] data_lines_i,
    output logic [7:0] data_lines_o,
    output logic data_lines_oe,
    // Peripheral port.
    input wire logic [7:0] peripheral_port_pins_i,
    output logic [7:0] peripheral_port_pins_o,
    output logic [7:0] peripheral_port_pins_oe
);
    import cpu_ctrl_pkg::*;

    seq_state_t state_q, state_d;
    cmd_t cmd_q, cmd_d;
    bus_cycle_t bus_q, bus_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] lo_q, lo_d;
    logic [7:0] ptr_q, ptr_d;
    logic [15:0] ea_d;
    logic [15:0] pc_d;
    logic [7:0] sp_d;
    logic [7:0] rdata_d;
    logic done_d;
    logic pc_load_d;
    logic mask_hw_set;
    logic ext_write_d;
    logic [7:0] port_dir_q;
    logic [7:0] port_out_q;
    logic [7:0] port_rd;
    logic [7:0] rd_byte;
    logic irq_take;
    logic port_hit;

    // Port read: register on outputs, pins on inputs.
    assign port_rd = (port_out_q & port_dir_q) | (peripheral_port_pins_i & ~port_dir_q); // [RL21]
    assign port_hit = (bus_q.addr == PORT_DIR_ADDR) || (bus_q.addr == PORT_OUT_ADDR);
    // Read byte; the port shadows the data lines.
    always_comb begin
        if (bus_q.addr == PORT_DIR_ADDR) begin
            rd_byte = port_dir_q; // [RL10]
        end else if (bus_q.addr == PORT_OUT_ADDR) begin
            rd_byte = port_rd; // [RL10] [RL25]
        end else begin
            rd_byte = data_lines_i;
        end
    end

    // Interrupt only at a boundary with the mask clear.
    assign irq_take = instr_boundary && !irq_n && !irq_mask_q; // [RL4] [RL5]

    // Sequencer: next state, next bus cycle and results.
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        bus_d = '{addr: bus_q.addr, rw: 1'b1, wdata: 8'h00};
        cnt_d = cnt_q;
        lo_d = lo_q;
        ptr_d = ptr_q;
        ea_d = ea_q;
        pc_d = pc_q;
        sp_d = stack_ptr_q;
        rdata_d = rdata_q;
        done_d = 1'b0;
        pc_load_d = 1'b0;
        mask_hw_set = 1'b0;
        case (state_q)
            ST_HOLD: begin
                cnt_d = 3'h0;
                if (cold_start_input_n) begin
                    state_d = ST_INIT; // [RL23]
                end
            end
            ST_INIT: begin
                cnt_d = cnt_q + 3'h1;
                if (cnt_q == INIT_CYCLES - 3'h1) begin
                    mask_hw_set = 1'b1; // [RL1]
                    bus_d.addr = VEC_RESET_LO; // [RL1]
                    state_d = ST_VEC_LO;
                end
            end
            ST_VEC_LO: begin
                lo_d = rd_byte;
                bus_d.addr = (cmd_q.mode == AM_IMPL) ? VEC_IRQ_HI : VEC_RESET_HI; // [RL1] [RL8]
                state_d = ST_VEC_HI;
            end
            ST_VEC_HI: begin
                pc_d = {rd_byte, lo_q}; // [RL1] [RL8]
                pc_load_d = 1'b1;
                done_d = 1'b1;
                bus_d.addr = IDLE_ADDR;
                state_d = ST_IDLE;
            end
            ST_IDLE: begin
                if (irq_take) begin
                    cmd_d.pc_next = pc_in;
                    sp_d = stack_ptr_in;
                    bus_d = '{addr: {STACK_PAGE, stack_ptr_in}, rw: 1'b0, wdata: pc_in[15:8]}; // [RL6]
                    state_d = ST_PUSH_H;
                end else if (cmd_valid) begin
                    cmd_d = cmd;
                    case (cmd.mode)
                        AM_ACC, AM_IMPL: begin
                            done_d = 1'b1; // [RL12]
                        end
                        AM_IMM: begin
                            rdata_d = cmd.byte2; // [RL12]
                            done_d = 1'b1;
                        end
                        AM_REL: begin
                            pc_d = cmd.pc_next + {{8{cmd.byte2[7]}}, cmd.byte2}; // [RL17]
                            pc_load_d = 1'b1;
                            done_d = 1'b1;
                        end
                        AM_INDX, AM_INDY: begin
                            ptr_d = (cmd.mode == AM_INDX) ? cmd.byte2 + cmd.index_x : cmd.byte2; // [RL18]
                            bus_d.addr = {8'h00, ptr_d};
                            state_d = ST_PTR_LO;
                        end
                        AM_IND: begin
                            bus_d.addr = {cmd.byte3, cmd.byte2}; // [RL20]
                            state_d = ST_PTR_LO;
                        end
                        default: begin
                            case (cmd.mode)
                                AM_ZP: ea_d = {8'h00, cmd.byte2}; // [RL14]
                                AM_ZPX: ea_d = {8'h00, cmd.byte2 + cmd.index_x}; // [RL15]
                                AM_ZPY: ea_d = {8'h00, cmd.byte2 + cmd.index_y}; // [RL15]
                                AM_ABSX: ea_d = {cmd.byte3, cmd.byte2} + {8'h00, cmd.index_x}; // [RL16]
                                AM_ABSY: ea_d = {cmd.byte3, cmd.byte2} + {8'h00, cmd.index_y}; // [RL16]
                                default: ea_d = {cmd.byte3, cmd.byte2}; // [RL13]
                            endcase
                            bus_d = '{addr: ea_d, rw: !cmd.write, wdata: cmd.wdata}; // [RL11]
                            state_d = ST_DATA;
                        end
                    endcase
                end
            end
            ST_PTR_LO: begin
                lo_d = rd_byte;
                if (cmd_q.mode == AM_IND) begin
                    bus_d.addr = bus_q.addr + 16'h0001; // [RL20]
                end else begin
                    bus_d.addr = {8'h00, ptr_q + 8'h01}; // [RL18] [RL19]
                end
                state_d = ST_PTR_HI;
            end
            ST_PTR_HI: begin
                if (cmd_q.mode == AM_IND) begin
                    pc_d = {rd_byte, lo_q}; // [RL20]
                    pc_load_d = 1'b1;
                    done_d = 1'b1;
                    bus_d.addr = IDLE_ADDR;
                    state_d = ST_IDLE;
                end else begin
                    if (cmd_q.mode == AM_INDY) begin
                        ea_d = {rd_byte, lo_q} + {8'h00, cmd_q.index_y}; // [RL19]
                    end else begin
                        ea_d = {rd_byte, lo_q}; // [RL18]
                    end
                    bus_d = '{addr: ea_d, rw: !cmd_q.write, wdata: cmd_q.wdata}; // [RL11]
                    state_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (bus_q.rw) begin
                    rdata_d = rd_byte;
                end
                done_d = 1'b1;
                bus_d.addr = IDLE_ADDR;
                state_d = ST_IDLE;
            end
            ST_PUSH_H: begin
                sp_d = stack_ptr_q - 8'h01;
                bus_d = '{addr: {STACK_PAGE, sp_d}, rw: 1'b0, wdata: cmd_q.pc_next[7:0]}; // [RL6]
                state_d = ST_PUSH_L;
            end
            ST_PUSH_L: begin
                sp_d = stack_ptr_q - 8'h01;
                bus_d = '{addr: {STACK_PAGE, sp_d}, rw: 1'b0, wdata: status_in}; // [RL6]
                state_d = ST_PUSH_P;
            end
            ST_PUSH_P: begin
                sp_d = stack_ptr_q - 8'h01;
                mask_hw_set = 1'b1; // [RL7]
                cmd_d.mode = AM_IMPL;
                bus_d.addr = VEC_IRQ_LO; // [RL8]
                state_d = ST_VEC_LO;
            end
            default: begin
                state_d = ST_HOLD;
            end
        endcase
        // Interrupt vector fetch reuses the start-up states.
        if (state_q == ST_INIT) begin
            cmd_d.mode = AM_ACC;
        end
        // Cold start held low aborts everything and blocks writes.
        if (!cold_start_input_n) begin
            state_d = ST_HOLD;
            bus_d = '{addr: IDLE_ADDR, rw: 1'b1, wdata: 8'h00}; // [RL22] [RL3]
            done_d = 1'b0;
            pc_load_d = 1'b0;
        end
    end

    // Data drive only for writes outside the port.
    assign ext_write_d = !bus_d.rw && (bus_d.addr != PORT_DIR_ADDR) && (bus_d.addr != PORT_OUT_ADDR); // [RL25]

    // Sequencer and working registers.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ST_HOLD;
            cmd_q <= '0;
            cnt_q <= 3'h0;
            lo_q <= 8'h00;
            ptr_q <= 8'h00;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            cnt_q <= cnt_d;
            lo_q <= lo_d;
            ptr_q <= ptr_d;
        end
    end

    // Results returned to the instruction core.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cmd_ready_q <= 1'b0;
            done_q <= 1'b0;
            ea_q <= 16'h0000;
            rdata_q <= 8'h00;
            pc_load_q <= 1'b0;
            pc_q <= 16'h0000;
            stack_ptr_q <= 8'h00;
        end else begin
            cmd_ready_q <= (state_d == ST_IDLE);
            done_q <= done_d;
            ea_q <= ea_d;
            rdata_q <= rdata_d;
            pc_load_q <= pc_load_d;
            pc_q <= pc_d;
            stack_ptr_q <= sp_d;
        end
    end

    // Interrupt mask: hardware set wins over a core clear.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_mask_q <= 1'b1;
        end else if (mask_hw_set || mask_set) begin
            irq_mask_q <= 1'b1; // [RL1] [RL7]
        end else if (mask_clr) begin
            irq_mask_q <= 1'b0;
        end
    end

    // Bus pins; address and direction enables follow the bus enable input, data enable also needs an outside write.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bus_q <= '{addr: IDLE_ADDR, rw: 1'b1, wdata: 8'h00};
            address_lines_oe <= 1'b0;
            xfer_dir_oe <= 1'b0;
            data_lines_oe <= 1'b0;
        end else begin
            bus_q <= bus_d;
            address_lines_oe <= bus_output_enable; // [RL9]
            xfer_dir_oe <= bus_output_enable; // [RL9] [RL3]
            data_lines_oe <= bus_output_enable && ext_write_d; // [RL9] [RL25]
        end
    end
    assign address_lines_o = bus_q.addr;
    assign xfer_dir_o = bus_q.rw;
    assign data_lines_o = bus_q.wdata;

    // Port registers take internal write cycles.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            port_dir_q <= PORT_DIR_RESET;
            port_out_q <= PORT_OUT_RESET;
        end else if (!bus_q.rw && port_hit) begin
            if (bus_q.addr == PORT_DIR_ADDR) begin
                port_dir_q <= bus_q.wdata; // [RL10]
            end else begin
                port_out_q <= bus_q.wdata; // [RL10]
            end
        end
    end
    assign peripheral_port_pins_o = port_out_q; // [RL24]
    assign peripheral_port_pins_oe = port_dir_q; // [RL24]

endmodule
`default_nettype wire

// *** cpu_ctrl_pkg.sv ***
// Constants, modes, states and structs of the control block.
package cpu_ctrl_pkg;

    // Vector locations fetched by the start-up and interrupt sequences.
    localparam logic [15:0] VEC_RESET_LO = 16'hFFFC;
    localparam logic [15:0] VEC_RESET_HI = 16'hFFFD;
    localparam logic [15:0] VEC_IRQ_LO = 16'hFFFE;
    localparam logic [15:0] VEC_IRQ_HI = 16'hFFFF;

    // On-chip port registers in page zero.
    localparam logic [15:0] PORT_DIR_ADDR = 16'h0000;
    localparam logic [15:0] PORT_OUT_ADDR = 16'h0001;
    localparam logic [7:0] PORT_DIR_RESET = 8'h00;
    localparam logic [7:0] PORT_OUT_RESET = 8'h00;

    // Stack page and start-up timing.
    localparam logic [7:0] STACK_PAGE = 8'h01;
    localparam logic [2:0] INIT_CYCLES = 3'h6;
    localparam logic [15:0] IDLE_ADDR = 16'h0000;

    // Addressing modes of a command.
    typedef enum logic [3:0] {
        AM_ACC = 4'b0000,
        AM_IMM = 4'b0001,
        AM_ABS = 4'b0010,
        AM_ZP = 4'b0011,
        AM_ZPX = 4'b0100,
        AM_ZPY = 4'b0101,
        AM_ABSX = 4'b0110,
        AM_ABSY = 4'b0111,
        AM_REL = 4'b1000,
        AM_INDX = 4'b1001,
        AM_INDY = 4'b1010,
        AM_IND = 4'b1011,
        AM_IMPL = 4'b1100
    } addr_mode_t;

    // Sequencer states.
    typedef enum logic [3:0] {
        ST_HOLD = 4'b0000,
        ST_INIT = 4'b0001,
        ST_VEC_LO = 4'b0010,
        ST_VEC_HI = 4'b0011,
        ST_IDLE = 4'b0100,
        ST_PTR_LO = 4'b0101,
        ST_PTR_HI = 4'b0110,
        ST_DATA = 4'b0111,
        ST_PUSH_H = 4'b1000,
        ST_PUSH_L = 4'b1001,
        ST_PUSH_P = 4'b1010
    } seq_state_t;

    // Command from the instruction core.
    typedef struct packed {
        addr_mode_t mode;
        logic write;
        logic [7:0] wdata;
        logic [7:0] byte2;
        logic [7:0] byte3;
        logic [7:0] index_x;
        logic [7:0] index_y;
        logic [15:0] pc_next;
    } cmd_t;

    // One bus cycle as driven on the pins.
    typedef struct packed {
        logic [15:0] addr;
        logic rw;
        logic [7:0] wdata;
    } bus_cycle_t;

endpackage

// *** placeholder_none.sv ***
// Empty file.

// *** mem_model.sv ***
// Memory model on the far side of the bus.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    // Clock.
    input wire logic clk_sys,
    // Bus cycle from the processor.
    input wire logic [15:0] addr,
    input wire logic addr_oe,
    input wire logic dir,
    input wire logic [7:0] wdata,
    input wire logic wdata_oe,
    // Read data back to the processor.
    output logic [7:0] rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    // Each byte starts as address low xor high.
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 8);
        end
    end
    // Stores when data is driven and direction low.
    always @(posedge clk_sys) begin
        if (wdata_oe && !dir) begin
            mem[addr] <= wdata;
        end
        last_q <= rdata;
    end
    // Answers at once; an undriven bus reads as a toggling value.
    assign rdata = (addr_oe && dir) ? mem[addr] : ~last_q;
endmodule
`default_nettype wire

// *** cpu_ctrl_addr_gen_props.sv ***
// Property checks for the control block.
`timescale 1ns/1ps
`default_nettype none
module cpu_ctrl_props (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // System and core inputs.
    input wire logic cold_start_input_n,
    input wire logic irq_n,
    input wire logic bus_output_enable,
    input wire logic instr_boundary,
    input wire logic [7:0] stack_ptr_in,
    input wire logic cmd_valid,
    input wire cpu_ctrl_pkg::cmd_t cmd,
    // Observed outputs.
    input wire logic cmd_ready_q,
    input wire logic pc_load_q,
    input wire logic irq_mask_q,
    input wire logic [15:0] address_lines_o,
    input wire logic address_lines_oe,
    input wire logic xfer_dir_o,
    input wire logic xfer_dir_oe,
    input wire logic data_lines_oe,
    input wire logic [7:0] peripheral_port_pins_o
);
    import cpu_ctrl_pkg::*;
    logic irq_take;
    logic cmd_take;
    // Accepted interrupt or command at this edge.
    assign irq_take = instr_boundary && !irq_n && !irq_mask_q && cmd_ready_q && cold_start_input_n;
    assign cmd_take = cmd_valid && cmd_ready_q && !irq_take && cold_start_input_n;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_hold_quiet;
        !cold_start_input_n |=> xfer_dir_o && !data_lines_oe;
    endproperty
    a_hold_quiet: assert property (p_hold_quiet)
        else $error("write during cold start");
    property p_init;
        $rose(cold_start_input_n) |-> ##7 address_lines_o == VEC_RESET_LO
            ##1 address_lines_o == VEC_RESET_HI ##1 pc_load_q && irq_mask_q;
    endproperty
    a_init: assert property (p_init)
        else $error("start-up fetch wrong");
    property p_irq_push;
        irq_take |=> address_lines_o == {STACK_PAGE, $past(stack_ptr_in)} && !xfer_dir_o
            ##1 address_lines_o == {STACK_PAGE, $past(stack_ptr_in, 2) - 8'h01} && !xfer_dir_o
            ##1 address_lines_o == {STACK_PAGE, $past(stack_ptr_in, 3) - 8'h02} && !xfer_dir_o;
    endproperty
    a_irq_push: assert property (p_irq_push)
        else $error("push wrong");
    property p_irq_vec;
        irq_take |-> ##4 address_lines_o == VEC_IRQ_LO ##1 address_lines_o == VEC_IRQ_HI
            ##1 pc_load_q && irq_mask_q;
    endproperty
    a_irq_vec: assert property (p_irq_vec)
        else $error("irq vector wrong");
    property p_idle;
        cmd_ready_q && cold_start_input_n && !cmd_valid && !irq_take |=> xfer_dir_o && !pc_load_q;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle not quiet");
    property p_oe;
        $past(rst_n) |-> address_lines_oe == $past(bus_output_enable)
            && xfer_dir_oe == $past(bus_output_enable);
    endproperty
    a_oe: assert property (p_oe)
        else $error("enables wrong");
    property p_data_drive;
        data_lines_oe |-> !xfer_dir_o && address_lines_oe && address_lines_o > PORT_OUT_ADDR;
    endproperty
    a_data_drive: assert property (p_data_drive)
        else $error("stray data drive");
    property p_zp;
        cmd_take && cmd.mode == AM_ZP |=> address_lines_o == {8'h00, $past(cmd.byte2)};
    endproperty
    a_zp: assert property (p_zp)
        else $error("zero page address wrong");
    property p_absy;
        cmd_take && cmd.mode == AM_ABSY |=>
            address_lines_o == {$past(cmd.byte3), $past(cmd.byte2)} + 16'($past(cmd.index_y));
    endproperty
    a_absy: assert property (p_absy)
        else $error("indexed absolute address wrong");
    property p_port;
        cmd_take && cmd.mode == AM_ZP && cmd.write && cmd.byte2 == 8'h01
            |-> ##2 peripheral_port_pins_o == $past(cmd.wdata, 2);
    endproperty
    a_port: assert property (p_port)
        else $error("port write lost");
    property p_ind;
        cmd_take && cmd.mode == AM_IND |-> ##3 pc_load_q;
    endproperty
    a_ind: assert property (p_ind)
        else $error("indirect jump load late");
endmodule
bind cpu_ctrl_addr_gen cpu_ctrl_props props_u (
    .clk_sys, .rst_n, .cold_start_input_n, .irq_n, .bus_output_enable, .instr_boundary,
    .stack_ptr_in, .cmd_valid, .cmd, .cmd_ready_q, .pc_load_q, .irq_mask_q, .address_lines_o,
    .address_lines_oe, .xfer_dir_o, .xfer_dir_oe, .data_lines_oe, .peripheral_port_pins_o
);
`default_nettype wire

// *** cpu_ctrl_and_address_gen_bench.sv ***
// Self-checking bench for the control block.
`timescale 1ns/1ps
`default_nettype none
module cpu_ctrl_and_address_gen_bench;
    import cpu_ctrl_pkg::*;
    typedef struct {
        addr_mode_t m;
        logic [7:0] b2, b3, x, y;
        logic w;
        logic [7:0] wd;
        logic [15:0] pcn, exp;
        int k, lat;
    } row_t;
    logic clk_sys = 1'b0, rst_n = 1'b0, cold_start_input_n = 1'b0, irq_n = 1'b1;
    logic bus_output_enable = 1'b1, instr_boundary = 1'b0, mask_set = 1'b0, mask_clr = 1'b0;
    logic cmd_valid = 1'b0;
    logic [7:0] stack_ptr_in = 8'hFF, status_in = 8'hA7, ext_q = 8'h3C;
    logic [15:0] pc_in = 16'h4321;
    cmd_t cmd = '0;
    logic cmd_ready_q, done_q, pc_load_q, irq_mask_q, address_lines_oe, xfer_dir_o, xfer_dir_oe;
    logic data_lines_oe;
    logic [15:0] ea_q, pc_q, address_lines_o;
    logic [7:0] rdata_q, stack_ptr_q, data_lines_i, data_lines_o;
    logic [7:0] peripheral_port_pins_i, peripheral_port_pins_o, peripheral_port_pins_oe;
    int fail_count = 0, comparisons = 0, n;
    // Each row: mode, byte2, byte3, X, Y, write, data, next pc, expected, kind, latency.
    row_t rows [15] = '{
        '{AM_ACC, '0, '0, '0, '0, '0, '0, '0, '0, 3, 1},
        '{AM_IMPL, '0, '0, '0, '0, '0, '0, '0, '0, 3, 1},
        '{AM_IMM, 8'h5A, '0, '0, '0, '0, '0, '0, 16'h005A, 2, 1},
        '{AM_ABS, 8'h34, 8'h12, '0, '0, '0, '0, '0, 16'h1234, 0, 2},
        '{AM_ABS, 8'h34, 8'h12, '0, '0, 1'b1, 8'hC3, '0, 16'h1234, 0, 2},
        '{AM_ZP, 8'h80, '0, '0, '0, '0, '0, '0, 16'h0080, 0, 2},
        '{AM_ZPX, 8'hF0, '0, 8'h20, '0, '0, '0, '0, 16'h0010, 0, 2},
        '{AM_ZPY, 8'hFF, '0, '0, 8'h03, '0, '0, '0, 16'h0002, 0, 2},
        '{AM_ABSX, 8'hF0, 8'h12, 8'h20, '0, '0, '0, '0, 16'h1310, 0, 2},
        '{AM_ABSY, 8'hFF, 8'h12, '0, 8'h01, '0, '0, '0, 16'h1300, 0, 2},
        '{AM_REL, 8'h80, '0, '0, '0, '0, '0, 16'h1000, 16'h0F80, 1, 1},
        '{AM_REL, 8'h7F, '0, '0, '0, '0, '0, 16'h10F0, 16'h116F, 1, 1},
        '{AM_INDX, 8'h0E, '0, 8'h04, '0, '0, '0, '0, 16'h1312, 0, 4},
        '{AM_INDY, 8'h10, '0, '0, 8'hF0, '0, '0, '0, 16'h1200, 0, 4},
        '{AM_IND, 8'hFC, 8'hFF, '0, '0, '0, '0, '0, 16'h0203, 1, 3}
    };
    // Pins: block value where driven, outside level elsewhere.
    assign peripheral_port_pins_i = (peripheral_port_pins_oe & peripheral_port_pins_o)
        | (~peripheral_port_pins_oe & ext_q);
    cpu_ctrl_addr_gen dut_u (
        .clk_sys, .rst_n, .cold_start_input_n, .irq_n, .bus_output_enable, .instr_boundary,
        .mask_set, .mask_clr, .stack_ptr_in, .status_in, .pc_in, .cmd_valid, .cmd, .cmd_ready_q,
        .done_q, .ea_q, .rdata_q, .pc_load_q, .pc_q, .stack_ptr_q, .irq_mask_q, .address_lines_o,
        .address_lines_oe, .xfer_dir_o, .xfer_dir_oe, .data_lines_i, .data_lines_o,
        .data_lines_oe, .peripheral_port_pins_i, .peripheral_port_pins_o, .peripheral_port_pins_oe
    );
    mem_model mem_u (.clk_sys, .addr(address_lines_o), .addr_oe(address_lines_oe),
        .dir(xfer_dir_o), .wdata(data_lines_o), .wdata_oe(data_lines_oe), .rdata(data_lines_i));
    // Free-running 25 MHz clock.
    always #20 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Counts falling edges to done, bounded.
    task automatic wait_done(output int cnt);
        cnt = 1;
        while (done_q !== 1'b1 && cnt < 16) begin
            @(negedge clk_sys);
            cnt++;
        end
    endtask
    // Issues one command and checks its answer.
    task automatic do_cmd(input row_t r);
        int c;
        cmd = '{r.m, r.w, r.wd, r.b2, r.b3, r.x, r.y, r.pcn};
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        wait_done(c);
        chk("latency", 16'(c), 16'(r.lat));
        case (r.k)
            0: chk("ea", ea_q, r.exp);
            1: chk("pc", pc_q, r.exp);
            2: chk("rdata", {8'h00, rdata_q}, r.exp);
            default: ;
        endcase
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Cuts a hang short far beyond the hundred or so cycles the tests take.
    initial begin
        #(40 * 3000);
        fail_count++;
        $display("BAD watchdog expected finish seen timeout");
        final_report();
    end
    // Start-up, mode table, then hand-written cases.
    initial begin
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        cold_start_input_n = 1'b1;
        wait_done(n);
        chk("reset_pc", pc_q, 16'h0203);
        chk("reset_mask", {15'h0, irq_mask_q}, 16'h0001);
        $display("test start-up done");
        foreach (rows[i]) do_cmd(rows[i]);
        chk("mem_write", {8'h00, mem_u.mem[16'h1234]}, 16'h00C3);
        $display("test mode table done");
        do_cmd('{AM_ZP, '0, '0, '0, '0, 1'b1, 8'h0F, '0, '0, 3, 2});
        do_cmd('{AM_ZP, 8'h01, '0, '0, '0, 1'b1, 8'hA5, '0, '0, 3, 2});
        chk("pin_oe", {8'h00, peripheral_port_pins_oe}, 16'h000F);
        chk("pin_out", {8'h00, peripheral_port_pins_o}, 16'h00A5);
        do_cmd('{AM_ZP, 8'h01, '0, '0, '0, '0, '0, '0, 16'h0035, 2, 2});
        chk("port_mem", {8'h00, mem_u.mem[1]}, 16'h0001);
        $display("test port done");
        mask_clr = 1'b1;
        @(negedge clk_sys);
        mask_clr = 1'b0;
        irq_n = 1'b0;
        instr_boundary = 1'b1;
        @(negedge clk_sys);
        instr_boundary = 1'b0;
        wait_done(n);
        chk("irq_time", 16'(n), 16'h0006);
        chk("irq_pc", pc_q, 16'h0001);
        chk("irq_mask", {15'h0, irq_mask_q}, 16'h0001);
        chk("irq_sp", {8'h00, stack_ptr_q}, 16'h00FC);
        chk("push_hi", {8'h00, mem_u.mem[16'h01FF]}, 16'h0043);
        chk("push_lo", {8'h00, mem_u.mem[16'h01FE]}, 16'h0021);
        chk("push_st", {8'h00, mem_u.mem[16'h01FD]}, 16'h00A7);
        stack_ptr_in = 8'hF0;
        instr_boundary = 1'b1;
        @(negedge clk_sys);
        instr_boundary = 1'b0;
        repeat (8) @(negedge clk_sys);
        chk("masked_mem", {8'h00, mem_u.mem[16'h01F0]}, 16'h00F1);
        chk("masked_pc", pc_q, 16'h0001);
        irq_n = 1'b1;
        $display("test interrupt done");
        bus_output_enable = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("addr_oe_off", {15'h0, address_lines_oe}, 16'h0000);
        chk("dir_oe_off", {15'h0, xfer_dir_oe}, 16'h0000);
        bus_output_enable = 1'b1;
        @(negedge clk_sys);
        chk("addr_oe_on", {15'h0, address_lines_oe}, 16'h0001);
        $display("test bus enable done");
        cmd = '{AM_INDY, 1'b1, 8'h77, 8'h10, '0, '0, 8'hF0, '0};
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cold_start_input_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("abort_dir", {15'h0, xfer_dir_o}, 16'h0001);
        chk("abort_mem", {8'h00, mem_u.mem[16'h1200]}, 16'h0012);
        cold_start_input_n = 1'b1;
        wait_done(n);
        chk("restart_pc", pc_q, 16'h0203);
        $display("test cold start abort done");
        final_report();
    end
endmodule
`default_nettype wire
